// *** bench/can_bit_timing_properties.sv ***
/* Port checker of the CAN bit timing unit.
   Assumes it is bound into every instance of can_bit_timing_unit. */
`timescale 1ns/1ns
module can_bit_timing_checker (
	// Clock, reset and bus side.
	input wire logic        sys_clk, reset_n, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0]  pstrb,
	// Answers, the CAN bus line and timing outputs.
	input wire logic        pready, pslverr, can_rx, sample_strobe,
	input wire logic        sampled_bit, bit_start, bus_idle
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// A falling bus edge while idle, and three clocks with no sample strobe after.
	sequence idle_fall; bus_idle && $fell(can_rx); endsequence
	sequence quiet_seg1; !sample_strobe [*3]; endsequence
	a_ready_bound: assert property ($rose(penable) && psel |-> ##[1:2] pready)
		else $error("access not answered in time");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
		else $error("sample strobe longer than one cycle");
	a_start_pulse: assert property (bit_start |=> !bit_start)
		else $error("bit start longer than one cycle");
	a_bit_update: assert property ($changed(sampled_bit) |-> sample_strobe)
		else $error("bit value changed off the sample point");
	a_start_busy: assert property ($fell(bus_idle) |-> bit_start)
		else $error("idle left without a bit start");
	a_hard_sync: assert property (idle_fall |=> bit_start)
		else $error("no hard sync on idle edge");
	a_seg1_quiet: assert property (bit_start |=> quiet_seg1)
		else $error("sample inside the first quanta");
endmodule
bind can_bit_timing_unit can_bit_timing_checker chk (.*);

// *** bench/can_bit_timing_unit_tb.sv ***
/* Testbench of the CAN bit timing unit over APB and the bus line.
   Assumes the unit package and the node model are compiled first. */
`timescale 1ns/1ns
module can_bit_timing_unit_tb;
	logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0;
	logic        pwrite = 0, pready, pslverr, can_rx, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  pstrb = 0;
	logic        sample_strobe, sampled_bit, bit_start, bus_idle;
	int          err_count = 0, checked = 0, cycles = 0, n, bt;
	// Prescaler, segment fields and sample mode of each run.
	logic [5:0]  pre [3] = '{6'h01, 6'h00, 6'h02};
	logic [3:0]  s1 [3] = '{4'h4, 4'h5, 4'h5};
	logic [2:0]  s2 [3] = '{3'h2, 3'h2, 3'h2};
	logic        trip [3] = '{1'h0, 1'h0, 1'h1};

	// Clock of 100 ns period.
	always #50 sys_clk = ~sys_clk;

	can_bit_timing_unit uut (.sys_clk(sys_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .can_rx(can_rx), .sample_strobe(sample_strobe),
		.sampled_bit(sampled_bit), .bit_start(bit_start),
		.bus_idle(bus_idle));
	can_node_model node (.sys_clk(sys_clk), .can_rx(can_rx));

	// Compares a seen value with the expected one.
	task automatic check(input string name, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; read data and error are taken with pready.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask

	// Counts clocks until the next bit start.
	task automatic wait_start();
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (bit_start !== 1'h1 && n < 400);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Cuts a hang short.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			complete_run();
		end
	end

	// Reset values, refusal, then three dominant bit times and a return to idle per timing setting.
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'h1;
		@(posedge sys_clk);
		apb(1'h0, can_bit_timing_pkg::timing0_offset, 32'h0000_0000);
		check("timing0 reset", rd, 32'h0000_0000);
		apb(1'h0, can_bit_timing_pkg::timing1_offset, 32'h0000_0000);
		check("timing1 reset", rd, 32'h0000_0024);
		apb(1'h0, can_bit_timing_pkg::status_offset, 32'h0000_0000);
		check("status idle", rd & 32'h0000_0003, 32'h0000_0003);
		apb(1'h0, 12'h100, 32'h0000_0000);
		check("unmapped err", 32'(er), 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, can_bit_timing_pkg::timing0_offset,
				{24'h00_0000, 2'(i), pre[i]});
			apb(1'h1, can_bit_timing_pkg::timing1_offset,
				{24'h00_0000, trip[i], s2[i], s1[i]});
			apb(1'h0, can_bit_timing_pkg::timing1_offset, 32'h0000_0000);
			check("timing1", rd, {24'h00_0000, trip[i], s2[i], s1[i]});
			apb(1'h1, can_bit_timing_pkg::control_offset, 32'h0000_0001);
			bt = (3 + s1[i] + s2[i]) * (pre[i] + 1);
			fork
				node.hold_level(1'h0, 3 * bt);
				begin
					wait_start();
					check("hard sync", n, 2);
					wait_start();
					check("bit period", n, bt);
					n = 0;
					do begin
						@(posedge sys_clk);
						n++;
					end while (sample_strobe !== 1'h1 && n < 400);
					check("dominant bit", sampled_bit, 0);
				end
			join
			node.hold_level(1'h1, 13 * bt);
			check("idle again", bus_idle, 1);
			check("recessive bit", sampled_bit, 1);
			apb(1'h1, can_bit_timing_pkg::control_offset, 32'h0000_0000);
		end
		complete_run();
	end
endmodule

// *** bench/can_node_model.sv ***
/* Model of the other CAN nodes sharing the bus.
   Assumes a recessive-high bus held high by a pull-up when released. */
`timescale 1ns/1ns
module can_node_model (
	// Clock and bus line.
	input  wire logic sys_clk,
	output logic      can_rx
);
	// The bus rests recessive while no node drives it.
	initial can_rx = 1'h1;
	// Holds one level for a count of clocks; called just after an edge.
	task automatic hold_level(input logic lvl, input int clocks);
		can_rx <= lvl;
		repeat (clocks) @(posedge sys_clk);
	endtask
endmodule

// *** hw/can_bit_timing_unit.sv ***
/*
 * CAN bit timing unit: quantum prescaler, three-segment bit time,
 * hard sync and resynchronization, one or three samples per bit,
 * with timing fields on an APB slave.
 * Assumes can_rx is synchronous to sys_clk; dominant is low.
 */
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module can_bit_timing_unit (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// CAN bus.
	input  wire logic        can_rx,
	// Bit timing outputs.
	output logic             sample_strobe,
	output logic             sampled_bit,
	output logic             bit_start,
	output logic             bus_idle
);

	typedef enum logic [2:0] {
		seg_sync   = 3'b001,
		seg_before = 3'b010,
		seg_after  = 3'b100
	} segment_t;

	typedef struct packed {
		logic [5:0] quantum_prescaler;
		logic [1:0] resync_jump_width;
		logic [3:0] segment_before_sample;
		logic [2:0] segment_after_sample;
		logic       triple_sample;
		logic       enable;
		segment_t   segment;
		logic [4:0] quanta;
		logic [4:0] limit;
		logic       synced;
		logic       prev_rx;
		logic [1:0] early;
		logic [3:0] recessive;
		logic       pready;
		logic [31:0] prdata;
		logic       pslverr;
		logic       sample_strobe;
		logic       sampled_bit;
		logic       bit_start;
		logic       bus_idle;
	} unit_state_t;

	unit_state_t state;
	unit_state_t next_state;
	logic        quantum_tick;
	logic        edge_seen;
	logic [4:0]  jump;
	logic [4:0]  phase_err;
	logic        vote;
	logic        restart_now;

	// Majority of three samples.
	function automatic logic majority(input logic a, input logic b,
					  input logic c);
		majority = (a & b) | (a & c) | (b & c);
	endfunction

	quantum_divider divider (
		.sys_clk           (sys_clk),
		.reset_n           (reset_n),
		.quantum_prescaler (state.quantum_prescaler),
		.restart           (restart_now),
		.quantum_tick      (quantum_tick)
	);

	// Recessive-to-dominant transition and effective jump width.
	assign edge_seen = state.prev_rx & ~can_rx;
	assign jump = {3'b000, state.resync_jump_width} + 5'd1;
	assign vote = majority(state.early[1], state.early[0], can_rx);

	// Next state of the bit timing, sampling and register logic.
	always_comb begin
		next_state = state;
		next_state.pready = 1'b0;
		next_state.pslverr = 1'b0;
		next_state.sample_strobe = 1'b0;
		next_state.bit_start = 1'b0;
		restart_now = 1'b0;
		next_state.prev_rx = can_rx;
		phase_err = 5'd0;

		// APB access phase, answered with one wait state.
		if (psel && penable && !state.pready) begin
			next_state.pready = 1'b1;
			next_state.prdata = 32'h0000_0000;
			unique case (paddr)
			can_bit_timing_pkg::timing0_offset: begin
				next_state.prdata[7:0] = {state.resync_jump_width,
							  state.quantum_prescaler};
			end
			can_bit_timing_pkg::timing1_offset: begin
				next_state.prdata[7:0] = {state.triple_sample,
							  state.segment_after_sample,
							  state.segment_before_sample};
			end
			can_bit_timing_pkg::control_offset: begin
				next_state.prdata[0] = state.enable;
			end
			can_bit_timing_pkg::status_offset: begin
				next_state.prdata[4:0] = {state.segment, state.bus_idle,
							  state.sampled_bit};
			end
			default: begin
				next_state.pslverr = 1'b1;
			end
			endcase
		end

		// A write lands only at the edge at which the master sees pready.
		if (psel && penable && state.pready && pwrite && pstrb[0]) begin
			unique case (paddr)
			can_bit_timing_pkg::timing0_offset: begin
				next_state.quantum_prescaler = pwdata[5:0];
				next_state.resync_jump_width = pwdata[7:6];
			end
			can_bit_timing_pkg::timing1_offset: begin
				next_state.segment_before_sample = pwdata[3:0];
				next_state.segment_after_sample = pwdata[6:4];
				next_state.triple_sample = pwdata[7];
			end
			can_bit_timing_pkg::control_offset: begin
				next_state.enable = pwdata[0];
			end
			default: begin
			end
			endcase
		end

		if (!state.enable) begin
			next_state.segment = seg_sync;
			next_state.quanta = 5'd0;
			next_state.bus_idle = 1'b1;
			next_state.recessive = 4'h0;
		end else if (edge_seen && state.bus_idle) begin
			// Hard sync: the next clock starts the sync quantum.
			next_state.segment = seg_sync;
			next_state.quanta = 5'd0;
			restart_now = 1'b1;
			next_state.bit_start = 1'b1;
			next_state.bus_idle = 1'b0;
			next_state.synced = 1'b1;
		end else begin
			// One resynchronization per bit, edges outside sync only.
			if (edge_seen && !state.synced &&
			    state.segment != seg_sync) begin
				next_state.synced = 1'b1;
				if (state.segment == seg_before) begin
					// Late edge: lengthen the first segment.
					phase_err = state.quanta + 5'd1;
					next_state.limit = state.limit +
						((phase_err < jump) ? phase_err : jump);
				end else begin
					// Early edge: shorten the second segment.
					phase_err = state.limit - state.quanta;
					if (phase_err <= jump) begin
						next_state.segment = seg_sync;
						next_state.quanta = 5'd0;
						restart_now = 1'b1;
						next_state.bit_start = 1'b1;
						next_state.synced = 1'b0;
					end else begin
						next_state.limit = state.limit - jump;
					end
				end
			end
			if (quantum_tick && !restart_now) begin
				unique case (state.segment)
				seg_sync: begin
					// Sync segment lasts one quantum.
					next_state.segment = seg_before;
					next_state.quanta = 5'd0;
					next_state.limit = {1'b0, state.segment_before_sample}
						;
				end
				seg_before: begin
					if (state.quanta + 5'd2 >= next_state.limit &&
					    state.quanta < next_state.limit) begin
						// Extra samples in the two quanta before the last one.
						next_state.early = {state.early[0], can_rx};
					end
					if (state.quanta >= next_state.limit) begin
						next_state.sample_strobe = 1'b1;
						next_state.sampled_bit = state.triple_sample ?
							vote : can_rx;
						next_state.segment = seg_after;
						next_state.quanta = 5'd0;
						next_state.limit = {2'b00,
							state.segment_after_sample};
					end else begin
						next_state.quanta = state.quanta + 5'd1;
					end
				end
				seg_after: begin
					if (state.quanta >= next_state.limit) begin
						next_state.segment = seg_sync;
						next_state.quanta = 5'd0;
						next_state.bit_start = 1'b1;
						next_state.synced = 1'b0;
						next_state.recessive = next_state.sampled_bit ?
							((state.recessive == can_bit_timing_pkg::idle_bits)
							 ? state.recessive : state.recessive + 4'h1)
							: 4'h0;
						if (next_state.recessive ==
						    can_bit_timing_pkg::idle_bits) begin
							next_state.bus_idle = 1'b1;
						end
					end else begin
						next_state.quanta = state.quanta + 5'd1;
					end
				end
				endcase
			end
		end
	end

	// Registers the whole unit state.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= '0;
			state.quantum_prescaler <= can_bit_timing_pkg::prescaler_reset;
			state.resync_jump_width <= can_bit_timing_pkg::jump_reset;
			state.segment_before_sample <= can_bit_timing_pkg::seg1_reset;
			state.segment_after_sample <= can_bit_timing_pkg::seg2_reset;
			state.segment <= seg_sync;
			state.prev_rx <= 1'b1;
			state.sampled_bit <= 1'b1;
			state.bus_idle <= 1'b1;
			state.early <= 2'b11;
		end else begin
			state <= next_state;
		end
	end

	assign pready = state.pready;
	assign prdata = state.prdata;
	assign pslverr = state.pslverr;
	assign sample_strobe = state.sample_strobe;
	assign sampled_bit = state.sampled_bit;
	assign bit_start = state.bit_start;
	assign bus_idle = state.bus_idle;

endmodule

// *** hw/quantum_divider.sv ***
/*
 * Time quantum divider: one-cycle enable every prescaler plus one clocks.
 * Assumes a single system clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module quantum_divider (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// Control.
	input  wire logic [5:0] quantum_prescaler,
	input  wire logic       restart,
	// Quantum enable.
	output logic            quantum_tick
);

	typedef struct packed {
		logic [5:0] count;
	} div_state_t;

	div_state_t state;
	div_state_t next_state;

	// Counts clocks; restart at an edge makes the next clock the first one.
	always_comb begin
		next_state = state;
		if (restart) begin
			next_state.count = 6'h00;
		end else if (state.count >= quantum_prescaler) begin
			next_state.count = 6'h00;
		end else begin
			next_state.count = state.count + 6'h01;
		end
	end

	// Registers the divider state.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// The tick marks the last clock of each quantum, with no extra delay.
	assign quantum_tick = (state.count >= quantum_prescaler);

endmodule

// *** include/can_bit_timing_pkg.sv ***
/*
 * Constants for the CAN bit timing unit: register offsets, field
 * positions, reset values and the idle bit count.
 * Assumes a 32-bit APB register bus with one word per register.
 */
// Functional notes
// - Bit time is sync segment plus first segment plus second segment.
// - One quantum lasts the clock period times prescaler plus one.
// - Sync segment is always exactly one quantum.
// - First segment lasts field plus one quanta; field valid 2 to 15.
// - Second segment lasts field plus one quanta; field valid 1 to 7.
// - Effective jump width is field plus one quanta.
// - Bus level read at end of first segment is the bit value.
// - Edge phase errors lengthen first or shorten second segment.
// - Edges outside the sync segment are phase errors to correct.
// - Three-sample mode takes two extra samples one quantum apart before.
// - First segment holds propagation and phase one; second is phase two.
// - Jump width field 0 to 3 limits one resynchronization.
// - Sample-count bit one votes three samples; zero takes one.
package can_bit_timing_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0]  timing0_index  = 10'h03F;
	localparam logic [9:0]  timing1_index  = 10'h04F;
	localparam logic [9:0]  control_index  = 10'h000;
	localparam logic [9:0]  status_index   = 10'h001;

	// Register byte offsets, one aligned word per register.
	localparam logic [11:0] timing0_offset = {timing0_index, 2'b00};
	localparam logic [11:0] timing1_offset = {timing1_index, 2'b00};
	localparam logic [11:0] control_offset = {control_index, 2'b00};
	localparam logic [11:0] status_offset  = {status_index, 2'b00};

	// Field positions in the timing words.
	localparam int prescaler_lsb = 0;
	localparam int jump_lsb      = 6;
	localparam int seg1_lsb      = 0;
	localparam int seg2_lsb      = 4;
	localparam int triple_bit    = 7;

	// Reset values of the fields.
	localparam logic [5:0] prescaler_reset = 6'h00;
	localparam logic [1:0] jump_reset      = 2'h0;
	localparam logic [3:0] seg1_reset      = 4'h4;
	localparam logic [2:0] seg2_reset      = 3'h2;

	// Recessive bits in a row after which the bus counts as idle.
	localparam logic [3:0] idle_bits = 4'hB;

endpackage
